// >>> hdl/drc_defs.vh
// Register offsets, field positions, reset values and curve constants
`ifndef DRC_DEFS_VH
`define DRC_DEFS_VH

// Register offsets on the control port
`define DRC_OFS_RMS_TIME     8'h56
`define DRC_OFS_PEAK_TIMES   8'h57
`define DRC_OFS_LIMITER      8'h59
`define DRC_OFS_COMPRESSOR   8'h5A
`define DRC_OFS_MAX_OUTPUT   8'h5B
`define DRC_OFS_GATE_EXP     8'h5C
`define DRC_OFS_MIN_OUTPUT   8'h5D
`define DRC_OFS_MODE         8'h60

// Mode control field positions
`define DRC_BIT_SUPPLY_TRACK 7
`define DRC_BIT_LIMITER_DETECTOR_SOURCE      6
`define DRC_BIT_LIMITER_ENABLE       5
`define DRC_BIT_COMP_EN      4
`define DRC_BIT_EXPANDER_ENABLE       3
`define DRC_BIT_GATE_EN      2
`define DRC_BIT_DYNAMICS_ENABLE_HI    1
`define DRC_BIT_DYNAMICS_ENABLE_LO    0

// Reset values
`define DRC_RST_MODE         8'h00
`define DRC_RST_RMS_TIME     4'h3
`define DRC_RST_PEAK_TIMES   8'h00
`define DRC_RST_LIMITER      7'h0C
`define DRC_RST_COMPRESSOR   7'h18
`define DRC_RST_MAX_OUTPUT   7'h0C
`define DRC_RST_GATE_EXP     8'hFF
`define DRC_RST_MIN_OUTPUT   4'hF

// Curve constants, levels in half-dB steps relative to full scale
`define LIMITER_THRESHOLD_FIELD_TOP           11'sd12
`define GATE_THRESHOLD_FIELD_TOP           11'sd102
`define EXPANDER_THRESHOLD_FIELD_TOP           11'sd72
`define DRC_STEP_3DB         11'sd6
`define DRC_HALF_DB_PER_BIT  11'sd12
`define DRC_LEVEL_SILENT     11'sh600

`endif

// >>> hdl/drc_core.v
// Dynamic range control stage with input sample FIFO
// How it works
// - Limiter clips output at maximum output level
// - Supply tracking replaces programmed maximum output level
// - Compressor lowers gain between its threshold and limiter
// - Expander raises gain between its lower and upper bounds
// - Gate forces samples to zero below gate threshold
// - Mode register holds tracking, source and enable bits
// - Gate acts only while its enable bit is set
// - Peak and rms levels both feed the gain
// - Peak follows rises at attack, falls at release
// - Attack code in upper nibble, doubling time per code
// - Release code in lower nibble, doubling time per code
// - Rms window code in low nibble, upper reserved
// - Rms window resets to code 0011
// - Gain comes from static curve of measured level
// - Thresholds compare input level; extremes bound output
// - Seven-bit thresholds: +6 dB down in 0.5 dB
// - Gate threshold upper nibble, expander lower nibble
// - Gate from -51 dB, expander from -36 dB, 3 dB
// - Middle region keeps unity slope
// - Minimum output from -51 dB in 3 dB steps
`timescale 1ns/1ps
`include "drc_defs.vh"
`default_nettype none

// Sample FIFO built from flip-flops, registered full and empty
module drc_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             reset_n,
  // Filling side
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Draining side
  output reg              out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg  [WIDTH-1:0] mem [0:DEPTH-1];   // Storage words
  reg  [AW-1:0]    wr_ptr;            // Next write slot
  reg  [AW-1:0]    rd_ptr;            // Next read slot
  reg  [AW:0]      count;             // Words held
  wire             push;              // Word accepted
  wire             pop;               // Word removed
  reg  [AW:0]      next_count;        // Fill after this edge

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  // Fill level update
  always @* begin
    next_count = count;
    if (push & ~pop) begin
      next_count = count + 1'b1;
    end else if (pop & ~push) begin
      next_count = count - 1'b1;
    end
  end

  // Pointers and flags; full and empty come straight from flops
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      count     <= {(AW+1){1'b0}};
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      count     <= next_count;
      in_ready  <= (next_count != DEPTH);
      out_valid <= (next_count != {(AW+1){1'b0}});
    end
  end

  // Storage has no reset; contents are only read once written
  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// Dynamic range control top
module drc_core #(
  parameter SW         = 16,   // Sample width
  parameter FIFO_DEPTH = 16    // Input FIFO depth
) (
  // Clock and reset
  input  wire          core_clk,
  input  wire          reset_n,
  // Register port
  input  wire [7:0]    reg_addr,
  input  wire          reg_write,
  input  wire [7:0]    reg_wdata,
  input  wire          reg_read,
  output reg  [7:0]    reg_rdata,
  // Measured speaker supply, already as maximum output code
  input  wire [6:0]    speaker_supply,
  // Upstream samples
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [SW-1:0] in_data,
  // Downstream samples
  output reg           out_valid,
  input  wire          out_ready,
  output reg  [SW-1:0] out_data
);
  // Sequencer states, one-hot
  localparam ST_IDLE = 4'b0001;
  localparam ST_DET  = 4'b0010;
  localparam ST_GAIN = 4'b0100;
  localparam ST_OUT  = 4'b1000;

  // Registers
  reg  [7:0]  dynamics_mode_ctrl;       // Mode control
  reg  [3:0]  rms_average_window;       // Rms window code
  reg  [7:0]  peak_detector_times;      // Attack and release codes
  reg  [6:0]  limiter_threshold;        // Limiter threshold code
  reg  [6:0]  compressor_threshold;     // Compressor threshold code
  reg  [6:0]  max_output_amplitude;     // Maximum output code
  reg  [7:0]  gate_expander_thresholds; // Gate and expander codes
  reg  [3:0]  min_output_field;         // Minimum output code

  // Datapath state
  reg  [3:0]     state;        // Sequencer
  reg  [SW-1:0]  sample;       // Sample in flight
  reg  [SW-1:0]  peak_env;     // Peak envelope, magnitude
  reg  [31:0]    ms_env;       // Mean square envelope
  wire           fifo_valid;   // FIFO holds a sample
  wire [SW-1:0]  fifo_data;    // FIFO head
  wire           fifo_pop;     // Take FIFO head

  // Field views
  wire        limiter_enable     = dynamics_mode_ctrl[`DRC_BIT_LIMITER_ENABLE];
  wire        compressor_enable  = dynamics_mode_ctrl[`DRC_BIT_COMP_EN];
  wire        expander_enable    = dynamics_mode_ctrl[`DRC_BIT_EXPANDER_ENABLE];
  wire        gate_enable        = dynamics_mode_ctrl[`DRC_BIT_GATE_EN];
  wire        limiter_detector_source_rms        = dynamics_mode_ctrl[`DRC_BIT_LIMITER_DETECTOR_SOURCE];
  wire        supply_track       = dynamics_mode_ctrl[`DRC_BIT_SUPPLY_TRACK];
  wire        dynamics_enable    =
    |dynamics_mode_ctrl[`DRC_BIT_DYNAMICS_ENABLE_HI:`DRC_BIT_DYNAMICS_ENABLE_LO];
  wire [3:0]  peak_attack_time   = peak_detector_times[7:4];
  wire [3:0]  peak_release_time  = peak_detector_times[3:0];
  wire [3:0]  gate_threshold_field     = gate_expander_thresholds[7:4];
  wire [3:0]  expander_threshold_field = gate_expander_thresholds[3:0];

  // Level of a 32-bit magnitude in half-dB below full scale
  function signed [10:0] level_of;
    input [31:0] v;
    integer      i;
    integer      msb;
    integer      lv;
    begin
      msb = -1;
      for (i = 0; i < 32; i = i + 1) begin
        if (v[i]) begin
          msb = i;
        end
      end
      if (msb < 0) begin
        level_of = `DRC_LEVEL_SILENT;
      end else begin
        lv = -12 * (31 - msb);
        // Next bit below the leading one adds about 3.5 dB
        if (msb > 0 && v[msb-1]) begin
          lv = lv + 7;
        end
        level_of = lv[10:0];
      end
    end
  endfunction

  // Seven-bit threshold code to level; +6 dB at code zero
  function signed [10:0] fine_level;
    input [6:0] code;
    begin
      fine_level = `LIMITER_THRESHOLD_FIELD_TOP - $signed({4'b0000, code});
    end
  endfunction

  // Four-bit code to level in 3 dB steps down from top
  function signed [10:0] coarse_level;
    input signed [10:0] top;
    input [3:0]         code;
    begin
      coarse_level = -top - `DRC_STEP_3DB * $signed({7'd0, code});
    end
  endfunction

  // Fractional 0.5 dB steps of the gain, Q2.14
  function [15:0] frac_gain;
    input [3:0] r;
    begin
      case (r)
        4'd0:    frac_gain = 16'h4000;
        4'd1:    frac_gain = 16'h43CE;
        4'd2:    frac_gain = 16'h47D6;
        4'd3:    frac_gain = 16'h4C1C;
        4'd4:    frac_gain = 16'h50A3;
        4'd5:    frac_gain = 16'h556E;
        4'd6:    frac_gain = 16'h5A82;
        4'd7:    frac_gain = 16'h5FE4;
        4'd8:    frac_gain = 16'h6598;
        4'd9:    frac_gain = 16'h6BA2;
        4'd10:   frac_gain = 16'h7209;
        4'd11:   frac_gain = 16'h78D1;
        default: frac_gain = 16'h4000;
      endcase
    end
  endfunction

  // Register writes; reserved bits are never stored
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dynamics_mode_ctrl       <= `DRC_RST_MODE;
      rms_average_window       <= `DRC_RST_RMS_TIME;
      peak_detector_times      <= `DRC_RST_PEAK_TIMES;
      limiter_threshold        <= `DRC_RST_LIMITER;
      compressor_threshold     <= `DRC_RST_COMPRESSOR;
      max_output_amplitude     <= `DRC_RST_MAX_OUTPUT;
      gate_expander_thresholds <= `DRC_RST_GATE_EXP;
      min_output_field         <= `DRC_RST_MIN_OUTPUT;
    end else if (reg_write) begin
      case (reg_addr)
        `DRC_OFS_MODE:       dynamics_mode_ctrl <= reg_wdata;
        `DRC_OFS_RMS_TIME:   rms_average_window <= reg_wdata[3:0];
        `DRC_OFS_PEAK_TIMES: peak_detector_times <= reg_wdata;
        `DRC_OFS_LIMITER:    limiter_threshold <= reg_wdata[6:0];
        `DRC_OFS_COMPRESSOR: compressor_threshold <= reg_wdata[6:0];
        `DRC_OFS_MAX_OUTPUT: max_output_amplitude <= reg_wdata[6:0];
        `DRC_OFS_GATE_EXP:   gate_expander_thresholds <= reg_wdata;
        `DRC_OFS_MIN_OUTPUT: min_output_field <= reg_wdata[3:0];
        default: begin
          // Unmapped offsets are ignored
        end
      endcase
    end
  end

  // Registered read data, reserved bits as zero
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `DRC_OFS_MODE:       reg_rdata <= dynamics_mode_ctrl;
        `DRC_OFS_RMS_TIME:   reg_rdata <= {4'h0, rms_average_window};
        `DRC_OFS_PEAK_TIMES: reg_rdata <= peak_detector_times;
        `DRC_OFS_LIMITER:    reg_rdata <= {1'b0, limiter_threshold};
        `DRC_OFS_COMPRESSOR: reg_rdata <= {1'b0, compressor_threshold};
        `DRC_OFS_MAX_OUTPUT: reg_rdata <= {1'b0, max_output_amplitude};
        `DRC_OFS_GATE_EXP:   reg_rdata <= gate_expander_thresholds;
        `DRC_OFS_MIN_OUTPUT: reg_rdata <= {4'h0, min_output_field};
        default:             reg_rdata <= 8'h00;
      endcase
    end
  end

  // Input FIFO; a full FIFO drops in_ready back to the source
  drc_fifo #(
    .WIDTH (SW),
    .DEPTH (FIFO_DEPTH),
    .AW    ($clog2(FIFO_DEPTH))
  ) u_fifo (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  assign fifo_pop = (state == ST_IDLE) & fifo_valid;

  // Detector inputs
  wire [SW-1:0] mag     = sample[SW-1] ? (~sample + 1'b1) : sample;
  wire [31:0]   mag_sq  = {{(32-SW){1'b0}}, mag} * {{(32-SW){1'b0}}, mag};
  wire [31:0]   pk_up   = {{(32-SW){1'b0}}, mag - peak_env} >> peak_attack_time;
  wire [31:0]   pk_dn   = {{(32-SW){1'b0}}, peak_env - mag} >> peak_release_time;
  wire [31:0]   ms_up   = (mag_sq - ms_env) >> rms_average_window;
  wire [31:0]   ms_dn   = (ms_env - mag_sq) >> rms_average_window;
  // A zero step at long times would stall the envelope; force one LSB
  wire [SW-1:0] pk_up_s = (pk_up == 32'd0) ? {{(SW-1){1'b0}}, 1'b1}
                                            : pk_up[SW-1:0];
  wire [SW-1:0] pk_dn_s = (pk_dn == 32'd0) ? {{(SW-1){1'b0}}, 1'b1}
                                            : pk_dn[SW-1:0];

  // Measured levels and curve points
  wire signed [10:0] peak_lv = level_of({peak_env, {(32-SW){1'b0}}});
  wire signed [10:0] sq_lv   = level_of({ms_env[29:0], 2'b00});
  wire signed [10:0] rms_lv  = sq_lv >>> 1;
  wire signed [10:0] lim_lv  = limiter_detector_source_rms ? rms_lv : peak_lv;
  wire signed [10:0] lt_lv   = fine_level(limiter_threshold);
  wire signed [10:0] ct_lv   = fine_level(compressor_threshold);
  wire [6:0]         smax_c  = supply_track ? speaker_supply
                                            : max_output_amplitude;
  wire signed [10:0] smax_lv = fine_level(smax_c);
  wire signed [10:0] nt_lv   = coarse_level(`GATE_THRESHOLD_FIELD_TOP,
                                            gate_threshold_field);
  wire signed [10:0] et_lv   = coarse_level(`EXPANDER_THRESHOLD_FIELD_TOP,
                                            expander_threshold_field);
  wire signed [10:0] smin_lv = coarse_level(`GATE_THRESHOLD_FIELD_TOP,
                                            min_output_field);

  // Static curve: gain in half-dB from the input level
  reg signed [10:0] gain;
  reg               mute;
  always @* begin
    gain = 11'sd0;
    mute = 1'b0;
    if (!dynamics_enable) begin
      gain = 11'sd0;
    end else if (gate_enable && rms_lv < nt_lv) begin
      mute = 1'b1;
    end else if (limiter_enable && lim_lv > lt_lv) begin
      gain = smax_lv - lim_lv;
    end else if (compressor_enable && rms_lv > ct_lv) begin
      gain = (ct_lv - rms_lv) >>> 1;
    end else if (expander_enable && rms_lv < et_lv) begin
      // Half the distance to the upper bound is added back
      gain = (et_lv - rms_lv) >>> 1;
      if (rms_lv + gain < smin_lv) begin
        gain = smin_lv - rms_lv;
      end
    end
  end

  // Gain in half-dB split into whole 6 dB shifts and a fraction
  wire signed [10:0] g_q  = (gain >= 0) ? (gain / 12)
                          : -((-gain + 11'sd11) / 12);
  wire signed [10:0] g_r  = gain - g_q * `DRC_HALF_DB_PER_BIT;
  wire signed [16:0] fr   = $signed({1'b0, frac_gain(g_r[3:0])});
  wire signed [33:0] prod = $signed(sample) * fr;
  wire signed [47:0] wide = {{14{prod[33]}}, prod} <<< 10;
  reg  signed [47:0] shifted;
  reg  [SW-1:0]      next_out;
  // Shift, then saturate to sample width
  always @* begin
    if (g_q >= 0) begin
      shifted = wide <<< g_q[4:0];
    end else begin
      shifted = wide >>> (-g_q);
    end
    if (mute) begin
      next_out = {SW{1'b0}};
    end else if (shifted[47:24+SW-1] != {(25-SW){shifted[47]}}) begin
      next_out = shifted[47] ? {1'b1, {(SW-1){1'b0}}}
                             : {1'b0, {(SW-1){1'b1}}};
    end else begin
      next_out = shifted[24+SW-1:24];
    end
  end

  // Sequencer: take, detect, apply gain, hand downstream
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= ST_IDLE;
      sample    <= {SW{1'b0}};
      peak_env  <= {SW{1'b0}};
      ms_env    <= 32'd0;
      out_valid <= 1'b0;
      out_data  <= {SW{1'b0}};
    end else begin
      case (state)
        ST_IDLE: begin
          if (fifo_valid) begin
            sample <= fifo_data;
            state  <= ST_DET;
          end
        end
        ST_DET: begin
          // Peak: attack on rise, release on fall
          if (mag > peak_env) begin
            peak_env <= (peak_attack_time == 4'd0) ? mag
                        : peak_env + pk_up_s;
          end else if (mag < peak_env) begin
            peak_env <= (peak_release_time == 4'd0) ? mag
                        : peak_env - pk_dn_s;
          end
          // Rms: one-pole average of the square
          if (mag_sq > ms_env) begin
            ms_env <= ms_env + ms_up;
          end else begin
            ms_env <= ms_env - ms_dn;
          end
          state <= ST_GAIN;
        end
        ST_GAIN: begin
          out_data  <= next_out;
          out_valid <= 1'b1;
          state     <= ST_OUT;
        end
        ST_OUT: begin
          if (out_ready) begin
            out_valid <= 1'b0;
            state     <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// >>> verif/drc_core_props.sv
// Port checker for the dynamic range stage
`timescale 1ns/1ps
`default_nettype none
module drc_props_chk #(
  parameter SW         = 16,
  parameter FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic          core_clk,
  input wire logic          reset_n,
  // Register port
  input wire logic [7:0]    reg_addr,
  input wire logic          reg_write,
  input wire logic [7:0]    reg_wdata,
  input wire logic          reg_read,
  input wire logic [7:0]    reg_rdata,
  input wire logic [6:0]    speaker_supply,
  // Sample stream
  input wire logic          in_valid,
  input wire logic          in_ready,
  input wire logic [SW-1:0] in_data,
  input wire logic          out_valid,
  input wire logic          out_ready,
  input wire logic [SW-1:0] out_data
);
  // Samples taken in but not yet handed on
  logic [7:0] pend;
  wire        push = in_valid && in_ready;
  wire        pop  = out_valid && out_ready;
  // Offsets that hold a register; all else reads zero
  wire mapd = reg_addr inside {8'h56, 8'h57, 8'h59, 8'h5A, 8'h5B,
                               8'h5C, 8'h5D, 8'h60};

  // Count in flight so an output can never appear from nothing
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend <= 8'h00;
    end else begin
      pend <= pend + {7'h00, push} - {7'h00, pop};
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_rdata_hold: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data changed with no read");
  a_unmapped_zero: assert property (reg_read && !mapd |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_top_bit_zero: assert property (reg_read &&
    reg_addr inside {8'h59, 8'h5A, 8'h5B} |=> !reg_rdata[7])
    else $error("reserved top bit reads one");
  a_rsvd_nibble: assert property (reg_read &&
    (reg_addr == 8'h56 || reg_addr == 8'h5D) |=> reg_rdata[7:4] == 4'h0)
    else $error("reserved nibble reads nonzero");
  a_mode_readback: assert property (reg_write && reg_addr == 8'h60
    ##1 !reg_write ##1 reg_read && reg_addr == 8'h60
    |=> reg_rdata == $past(reg_wdata, 3))
    else $error("mode register readback differs");
  a_out_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data)) else $error("output dropped early");
  a_gap_after: assert property (pop |=> !out_valid)
    else $error("no idle cycle after a handoff");
  a_no_phantom: assert property ($rose(out_valid) |-> pend != 8'h00)
    else $error("output with no sample taken");
  a_pend_bound: assert property (pend <= FIFO_DEPTH + 2)
    else $error("more samples held than storage allows");
endmodule

bind drc_core drc_props_chk #(.SW(SW), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .speaker_supply(speaker_supply),
  .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
  .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
`default_nettype wire

// >>> verif/drc_sink_model.sv
// Downstream sink model accepting samples with random stalls
`timescale 1ns/1ps
`default_nettype none
module drc_sink_model (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Long stall asked by the bench
  input  wire logic hold,
  // Sample handshake
  output var  logic out_ready
);
  // Redrawn each cycle so the stage meets prompt and slow acceptance
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= !hold && ($urandom % 4 != 0);
    end
  end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the dynamic range stage
`timescale 1ns/1ps
`include "drc_defs.vh"
`default_nettype none
module tb_top;
  typedef struct {logic [15:0] v; logic [15:0] lo; bit b;} drc_exp_t;
  logic        core_clk, reset_n, reg_write, reg_read, hold;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [6:0]  speaker_supply;
  logic        in_valid, in_ready, out_valid, out_ready;
  logic [15:0] in_data, out_data, d;
  logic        rd_d, saw_full;
  int          bad_count = 0;
  int          tests_run = 0;
  logic [7:0]  q_reg[$];   // Expected read data, oldest first
  drc_exp_t    q_smp[$];   // Expected samples; b set: lo < magnitude <= v
  // Offsets, reset values and readback after writing all ones
  logic [7:0] ofs[9] = '{`DRC_OFS_RMS_TIME, `DRC_OFS_PEAK_TIMES,
    `DRC_OFS_LIMITER, `DRC_OFS_COMPRESSOR, `DRC_OFS_MAX_OUTPUT,
    `DRC_OFS_GATE_EXP, `DRC_OFS_MIN_OUTPUT, `DRC_OFS_MODE, 8'h58};
  logic [7:0] rst[9] = '{8'h03, 8'h00, 8'h0C, 8'h18, 8'h0C, 8'hFF, 8'h0F,
    8'h00, 8'h00};
  logic [7:0] msk[9] = '{8'h0F, 8'hFF, 8'h7F, 8'h7F, 8'h7F, 8'hFF, 8'h0F,
    8'hFF, 8'h00};
  logic [7:0] lmd[3] = '{8'h21, 8'hA1, 8'hE1};  // Peak, tracking, rms
  logic [7:0] smx[3] = '{8'h50, 8'h00, 8'h00};

  drc_core #(.SW(16), .FIFO_DEPTH(16)) dut_u (.core_clk(core_clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .speaker_supply(speaker_supply), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data));
  drc_sink_model sink_u (.core_clk(core_clk), .reset_n(reset_n),
    .hold(hold), .out_ready(out_ready));

  // 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Exact match, or a magnitude window where the curve is approximate
  task automatic cmp_smp(input logic [15:0] got, input drc_exp_t e);
    logic [15:0] mag;
    mag = got[15] ? -got : got;
    tests_run++;
    if (e.b ? ((mag <= e.v && mag > e.lo) !== 1'b1) : (got !== e.v)) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e.v);
    end
  endtask

  // Watcher: read data lands one cycle after the read edge
  always @(posedge core_clk) begin
    rd_d <= reg_read;
    if (!in_ready) saw_full <= 1'b1;
    if (rd_d) cmp_reg(reg_rdata, q_reg.pop_front());
    if (out_valid && out_ready) cmp_smp(out_data, q_smp.pop_front());
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    q_reg.push_back(exp);
    @(posedge core_clk);
    reg_read <= 1'b0;
  endtask

  // Hold the sample until the stage takes it, then note the result
  task automatic snd(input logic [15:0] x, input logic [15:0] ev,
                     input bit b, input logic [15:0] lo);
    drc_exp_t e;
    e.v = ev;
    e.lo = lo;
    e.b = b;
    @(posedge core_clk);
    in_valid <= 1'b1;
    in_data  <= x;
    @(posedge core_clk);
    while (in_ready !== 1'b1) @(posedge core_clk);
    q_smp.push_back(e);
    in_valid <= 1'b0;
  endtask

  // Mode changes wait until nothing is in flight; a stall is a mismatch
  task automatic drain;
    for (int k = 0; k < 500 && q_smp.size() != 0; k++) @(posedge core_clk);
    if (q_smp.size() != 0) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, q_smp.size(), 0);
      q_smp.delete();
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog well past the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    end_sim;
  end

  initial begin
    {reset_n, reg_write, reg_read, hold, in_valid, rd_d, saw_full} = 7'h00;
    {reg_addr, reg_wdata, speaker_supply} = 23'h00_0000;
    in_data = 16'h0000;
    d = 16'($urandom(32'h0000_a9b4));
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 9; i++) rd(ofs[i], rst[i]);
    for (int i = 0; i < 9; i++) begin
      wr(ofs[i], 8'hFF);
      rd(ofs[i], msk[i]);
    end
    // Overall enable off: unity while the sink stalls and storage fills
    wr(`DRC_OFS_MODE, 8'hFC);
    hold <= 1'b1;
    fork
      for (int i = 0; i < 24; i++) begin
        d = 16'($urandom);
        snd(d, d, 1'b0, 16'h0000);
      end
      begin
        repeat (80) @(posedge core_clk);
        hold <= 1'b0;
      end
    join
    drain;
    // Quiet samples: gated to zero, then passed once the gate is off
    wr(`DRC_OFS_RMS_TIME, 8'h00);
    wr(`DRC_OFS_PEAK_TIMES, 8'h00);
    wr(`DRC_OFS_GATE_EXP, 8'h0F);
    for (int g = 0; g < 2; g++) begin
      wr(`DRC_OFS_MODE, g ? 8'h01 : 8'h05);
      for (int i = 0; i < 6; i++) begin
        d = 16'($urandom % 7) - 16'h0003;
        snd(d, g ? d : 16'h0000, 1'b0, 16'h0000);
      end
      drain;
    end
    // Loud samples capped near the maximum output, programmed or tracked
    wr(`DRC_OFS_LIMITER, 8'h50);
    speaker_supply <= 7'h50;
    for (int m = 0; m < 3; m++) begin
      wr(`DRC_OFS_MAX_OUTPUT, smx[m]);
      wr(`DRC_OFS_MODE, lmd[m]);
      snd(16'h4000, 16'h0400, 1'b1, 16'h0100);
      snd(16'hC000, 16'h0400, 1'b1, 16'h0100);
      drain;
    end
    // Above the compressor threshold the level comes down
    wr(`DRC_OFS_LIMITER, 8'h00);
    wr(`DRC_OFS_COMPRESSOR, 8'h50);
    wr(`DRC_OFS_MODE, 8'h11);
    snd(16'h4000, 16'h1FFF, 1'b1, 16'h0400);
    drain;
    // Weak level below the expander threshold comes up; mid level passes
    wr(`DRC_OFS_GATE_EXP, 8'hF0);
    wr(`DRC_OFS_MODE, 8'h09);
    snd(16'hFF00, 16'h0200, 1'b1, 16'h0100);
    snd(16'h2000, 16'h2000, 1'b0, 16'h0000);
    drain;
    cmp_reg({7'h00, saw_full}, 8'h01);
    end_sim;
  end
endmodule
`default_nettype wire
